// [logic/otpps_cfg.svh]
// Register indices, field positions and constants of the programming status block.
`ifndef OTPPS_CFG_SVH
`define OTPPS_CFG_SVH
`define OTPPS_IDX_PROG_STAT 14'h0519
`define OTPPS_IDX_PAGE1_STAT 14'h051a
`define OTPPS_IDX_PROG_CTRL 14'h0600
`define OTPPS_IDX_UNLOCK 14'h0601
`define OTPPS_IDX_IRQ_STAT 14'h0602
`define OTPPS_IDX_IRQ_MASK 14'h0603
`define OTPPS_UNLOCK_KEY 8'ha5
`define OTPPS_GO_BIT 0
`define OTPPS_F_OVERHEAT 0
`define OTPPS_F_LOW 1
`define OTPPS_F_HIGH 2
`define OTPPS_F_CHK_LOW 3
`define OTPPS_F_CHK_HIGH 4
`define OTPPS_NFAULT 5
`define OTPPS_NIRQ 4
`endif

// [logic/otpps_pkg.sv]
// Types shared by the programming status block.
package otpps_pkg;
    typedef enum logic [1:0] {
        OTPPS_IDLE = 2'b01,
        OTPPS_PROG = 2'b10
    } otpps_state_t;
endpackage

// [logic/otpps_top.sv]
// Programming status and page one status registers behind an APB slave.
//
// Operation
// - Other register writes relock and clear permit.
// - Go bit clears permit; permit one means unlocked.
// - Overvoltage during programming sets error; go clears.
// - Locked, tried or misformatted page sets setting error.
// - Completion flag set at finish, go clears.
// - Loaded flag shows page one loaded.
// - Load warning shows single-error corrections.
// - Load error shows double-error detection.
// - Format error: supply flags set without attempt.
// - Valid flag shows page successfully programmed.
// - Undervoltage-ok clears on undervoltage or overvoltage.
// - Overvoltage-ok clears on overvoltage, forcing undervoltage.
// - First-attempt flag set once programming tried.
`timescale 1ns/10ps
`include "otpps_cfg.svh"
module otpps_top (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [`OTPPS_NFAULT-1:0] i_fault,
    input wire logic i_prog_done,
    input wire logic i_load_done,
    input wire logic i_load_sec,
    input wire logic i_load_ded,
    input wire logic [3:0] i_load_flags,
    output logic o_prog_start,
    output logic o_prog_abort,
    output logic o_irq
);
    // Address decode: each register index sits on an aligned word.
    wire logic [15:0] a_stat = {`OTPPS_IDX_PROG_STAT, 2'b00};
    wire logic [15:0] a_page = {`OTPPS_IDX_PAGE1_STAT, 2'b00};
    wire logic [15:0] a_ctrl = {`OTPPS_IDX_PROG_CTRL, 2'b00};
    wire logic [15:0] a_key = {`OTPPS_IDX_UNLOCK, 2'b00};
    wire logic [15:0] a_ist = {`OTPPS_IDX_IRQ_STAT, 2'b00};
    wire logic [15:0] a_imsk = {`OTPPS_IDX_IRQ_MASK, 2'b00};
    wire logic hit_stat = (i_paddr == a_stat);
    wire logic hit_page = (i_paddr == a_page);
    wire logic hit_ctrl = (i_paddr == a_ctrl);
    wire logic hit_key = (i_paddr == a_key);
    wire logic hit_ist = (i_paddr == a_ist);
    wire logic hit_imsk = (i_paddr == a_imsk);
    wire logic hit_any = hit_stat | hit_page | hit_ctrl | hit_key | hit_ist | hit_imsk;
    // The slave answers at once, so every access phase completes.
    wire logic access = i_psel & i_penable;
    wire logic setup = i_psel & ~i_penable;
    wire logic wr = access & i_pwrite;
    wire logic wr_ctrl = wr & hit_ctrl;
    wire logic wr_key = wr & hit_key;
    wire logic wr_other = wr & ~hit_ctrl & ~hit_key;

    // Status state.
    otpps_pkg::otpps_state_t state; // Programming sequencer state.
    otpps_pkg::otpps_state_t next_state;
    logic unlock; // Programming permit.
    logic [`OTPPS_NFAULT-1:0] err; // Supply and heat errors.
    logic page_setting_err;
    logic done;
    logic loaded;
    logic fetch_warning;
    logic fetch_error;
    logic page_valid;
    logic supply_low_clear;
    logic supply_high_clear;
    logic first_attempt;
    logic [`OTPPS_NIRQ-1:0] irq_stat; // Sticky events: load, fault, setting error, done.
    logic [`OTPPS_NIRQ-1:0] irq_mask;
    logic next_unlock;
    logic [`OTPPS_NFAULT-1:0] next_err;
    logic next_pse;
    logic next_done;
    logic next_loaded;
    logic next_warn;
    logic next_ferr;
    logic next_valid;
    logic next_supply_low_clear;
    logic next_supply_high_clear;
    logic next_try;
    logic next_start;
    logic next_abort;

    // Format error is a pure function of the stored page flags.
    wire logic format_error = (supply_low_clear | supply_high_clear) & ~first_attempt;
    wire logic idle = (state == otpps_pkg::OTPPS_IDLE);
    wire logic busy = (state == otpps_pkg::OTPPS_PROG);
    // A go request while busy is ignored so a running page is never disturbed.
    wire logic go = wr_ctrl & i_pwdata[`OTPPS_GO_BIT] & idle;
    wire logic go_bad = ~unlock | first_attempt | format_error;
    wire logic fault_hit = busy & (|i_fault);
    wire logic done_hit = busy & ~(|i_fault) & i_prog_done;
    wire logic load_hit = idle & i_load_done;
    wire logic [`OTPPS_NIRQ-1:0] irq_ev = {load_hit, fault_hit, go & go_bad, done_hit};

    wire logic [7:0] prog_status = {unlock, err[`OTPPS_F_OVERHEAT], err[`OTPPS_F_LOW],
        err[`OTPPS_F_HIGH], err[`OTPPS_F_CHK_LOW], err[`OTPPS_F_CHK_HIGH],
        page_setting_err, done};
    wire logic [7:0] page_status = {loaded, fetch_warning, fetch_error, format_error,
        page_valid, supply_low_clear, supply_high_clear, first_attempt};
    wire logic [31:0] rd_mux = hit_stat ? {24'h000000, prog_status} :
        hit_page ? {24'h000000, page_status} :
        hit_ist ? {28'h0000000, irq_stat} :
        hit_imsk ? {28'h0000000, irq_mask} : 32'h00000000;

    assign o_pready = 1'b1;
    assign o_pslverr = access & ~hit_any;
    assign o_irq = |(irq_stat & irq_mask);

    // Next-state logic for the permit, the error flags and the page flags.
    always_comb begin
        next_state = state;
        next_unlock = unlock;
        next_err = err;
        next_pse = page_setting_err;
        next_done = done;
        next_loaded = loaded;
        next_warn = fetch_warning;
        next_ferr = fetch_error;
        next_valid = page_valid;
        next_supply_low_clear = supply_low_clear;
        next_supply_high_clear = supply_high_clear;
        next_try = first_attempt;
        next_start = 1'b0;
        next_abort = 1'b0;
        // The permit opens only by the key; the host then owes a control write.
        if (wr_key) begin
            next_unlock = (i_pwdata[7:0] == `OTPPS_UNLOCK_KEY);
        end else if (wr_other) begin
            next_unlock = 1'b0;
        end
        if (go) begin
            // Go wipes the previous outcome before judging the new request.
            next_unlock = 1'b0;
            next_err = '0;
            next_pse = 1'b0;
            next_done = 1'b0;
            if (go_bad) begin
                next_pse = 1'b1;
            end else begin
                // Supply flags start good and are knocked down by faults.
                next_state = otpps_pkg::OTPPS_PROG;
                next_try = 1'b1;
                next_supply_low_clear = 1'b1;
                next_supply_high_clear = 1'b1;
                next_valid = 1'b0;
                next_start = 1'b1;
            end
        end
        if (fault_hit) begin
            // Any fault aborts; the page is left tried but not valid.
            next_err = err | i_fault;
            next_state = otpps_pkg::OTPPS_IDLE;
            next_abort = 1'b1;
            if (i_fault[`OTPPS_F_LOW]) begin
                next_supply_low_clear = 1'b0;
            end
            if (i_fault[`OTPPS_F_HIGH]) begin
                next_supply_low_clear = 1'b0;
                next_supply_high_clear = 1'b0;
            end
        end else if (done_hit) begin
            next_done = 1'b1;
            next_valid = 1'b1;
            next_state = otpps_pkg::OTPPS_IDLE;
        end
        if (load_hit) begin
            // A load restores the stored page flags and reports its decode outcome.
            next_loaded = 1'b1;
            next_warn = i_load_sec;
            next_ferr = i_load_ded;
            {next_valid, next_supply_low_clear, next_supply_high_clear, next_try} = i_load_flags;
        end
    end

    // Sequencer and flag registers; the state resets to OTPPS_IDLE, everything else to zero.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state <= otpps_pkg::OTPPS_IDLE;
            {unlock, err, page_setting_err, done} <= '0;
            {loaded, fetch_warning, fetch_error, page_valid} <= 4'h0;
            {supply_low_clear, supply_high_clear, first_attempt} <= 3'h0;
            {o_prog_start, o_prog_abort} <= 2'h0;
        end else begin
            state <= next_state;
            {unlock, err, page_setting_err, done} <= {next_unlock, next_err, next_pse, next_done};
            {loaded, fetch_warning, fetch_error, page_valid} <=
                {next_loaded, next_warn, next_ferr, next_valid};
            {supply_low_clear, supply_high_clear, first_attempt} <=
                {next_supply_low_clear, next_supply_high_clear, next_try};
            {o_prog_start, o_prog_abort} <= {next_start, next_abort};
        end
    end

    // Interrupt status: a new event beats a write-one clear in the same cycle.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
        end else begin
            irq_stat <= (irq_stat & ~({4{wr & hit_ist}} & i_pwdata[3:0])) | irq_ev;
            if (wr & hit_imsk) begin
                irq_mask <= i_pwdata[3:0];
            end
        end
    end

    // Read data is captured in the setup phase so it stands from a flip-flop.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_prdata <= 32'h00000000;
        end else if (setup & ~i_pwrite) begin
            o_prdata <= rd_mux;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    property p_relock;
        wr_other |=> !unlock;
    endproperty
    a_relock: assert property (p_relock) else $error("permit survived another write");

    // Only a key write in the cycle after go may reopen the permit one cycle later.
    property p_go_lock;
        go |=> !unlock ##1 (!unlock || $past(wr_key));
    endproperty
    a_go_lock: assert property (p_go_lock) else $error("permit survived go");

    property p_high_err;
        fault_hit && i_fault[`OTPPS_F_HIGH] |=> err[`OTPPS_F_HIGH] && !supply_high_clear
            && !supply_low_clear && o_prog_abort && idle;
    endproperty
    a_high_err: assert property (p_high_err) else $error("overvoltage not recorded");

    property p_setting;
        go && (!unlock || first_attempt) |=> page_setting_err && !o_prog_start && idle;
    endproperty
    a_setting: assert property (p_setting) else $error("bad go not flagged");

    property p_clear;
        go |=> !done && !(|err);
    endproperty
    a_clear: assert property (p_clear) else $error("go left old outcome");

    property p_done;
        done_hit |=> done && page_valid && idle;
    endproperty
    a_done: assert property (p_done) else $error("completion not recorded");

    property p_load;
        load_hit |=> loaded && fetch_error == $past(i_load_ded)
            && fetch_warning == $past(i_load_sec);
    endproperty
    a_load: assert property (p_load) else $error("load outcome lost");

    property p_fmt;
        load_hit && i_load_flags == 4'h4 |=> format_error && !first_attempt;
    endproperty
    a_fmt: assert property (p_fmt) else $error("format error missed");

    property p_try;
        o_prog_start |-> first_attempt && supply_low_clear && supply_high_clear && busy;
    endproperty
    a_try: assert property (p_try) else $error("start without attempt flag");

    property p_irq;
        |(irq_ev & irq_mask) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked event gave no interrupt");
endmodule

// [tb/otp_program_status_tb_top.sv]
// Self-checking testbench of the programming status block.
`timescale 1ns/10ps
`include "otpps_cfg.svh"
module otp_program_status_tb_top;
    localparam logic [15:0] A_PS = {`OTPPS_IDX_PROG_STAT, 2'b00};
    localparam logic [15:0] A_P1 = {`OTPPS_IDX_PAGE1_STAT, 2'b00};
    localparam logic [15:0] A_CTRL = {`OTPPS_IDX_PROG_CTRL, 2'b00};
    localparam logic [15:0] A_KEY = {`OTPPS_IDX_UNLOCK, 2'b00};
    localparam logic [15:0] A_IRQ = {`OTPPS_IDX_IRQ_STAT, 2'b00};
    localparam logic [15:0] A_MASK = {`OTPPS_IDX_IRQ_MASK, 2'b00};
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [4:0] fault = 5'h00;
    logic prog_done = 1'b0;
    logic load_done = 1'b0;
    logic load_sec = 1'b0;
    logic load_ded = 1'b0;
    logic [3:0] load_flags = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic prog_start;
    logic prog_abort;
    logic irq;
    logic [31:0] rdata;
    logic err;
    // Reference model state, kept as plain integers.
    int m_unlock, m_ps, m_p1, m_irq, m_mask, m_busy, m_starts, m_aborts;
    int mismatches, comparisons, starts, aborts, seed, i, k;
    otpps_top dut_u (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_fault(fault), .i_prog_done(prog_done),
        .i_load_done(load_done), .i_load_sec(load_sec), .i_load_ded(load_ded),
        .i_load_flags(load_flags), .o_prog_start(prog_start), .o_prog_abort(prog_abort),
        .o_irq(irq));
    // The clock toggles every 20 ns, a period of 40 ns.
    always #20 ref_clk = ~ref_clk;
    // Start and abort pulses stand one cycle, so each edge counts at most one.
    always @(posedge ref_clk) begin
        if (prog_start === 1'b1) starts++;
        if (prog_abort === 1'b1) aborts++;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        // A slave that never answers is a failure, not a hang.
        if (n >= 16) begin
            mismatches++;
            report_and_stop();
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic int ps_exp();
        return m_ps | (m_unlock << 7);
    endfunction
    // The format flag is derived from the supply flags and the attempt flag.
    function automatic int p1_exp();
        return m_p1 | (((((m_p1 >> 1) & 3) != 0) && ((m_p1 & 1) == 0)) << 4);
    endfunction
    // Reads a register and compares it, the error response and the interrupt line.
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(rdata, exp);
        check({31'h0, err}, 32'h0);
        check({31'h0, irq}, {31'h0, (m_irq & m_mask) != 0});
    endtask
    // Writes a register and updates the model; a key write sets unlock from the key, any other write clears it.
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        int bad;
        apb(1'b1, a, d);
        bad = (m_unlock == 0) || (m_p1 & 1) || (p1_exp() & 16);
        if (a == A_CTRL && d[0]) begin
            m_ps = bad ? 2 : 0;
            m_irq |= bad ? 2 : 0;
            m_busy = !bad;
            m_starts += !bad;
            if (!bad) m_p1 = (m_p1 & 8'hf0) | 7;
        end
        if (a == A_MASK) m_mask = d & 15;
        if (a == A_IRQ) m_irq &= ~d;
        m_unlock = (a == A_KEY) && (d[7:0] == `OTPPS_UNLOCK_KEY);
    endtask
    // Ends a programming run by a fault (k below 5) or by completion.
    task automatic finish_run(input int k);
        @(posedge ref_clk);
        if (k < 5) fault <= 5'h01 << k;
        else prog_done <= 1'b1;
        @(posedge ref_clk);
        fault <= 5'h00;
        prog_done <= 1'b0;
        m_busy = 0;
        m_ps |= (k < 5) ? (1 << (6 - k)) : 1;
        m_irq |= (k < 5) ? 4 : 1;
        m_aborts += (k < 5);
        m_p1 &= (k == 1) ? ~4 : (k == 2) ? ~6 : ~0;
        if (k == 5) m_p1 |= 8;
    endtask
    task automatic load(input logic sec, input logic ded, input logic [3:0] fl);
        @(posedge ref_clk);
        load_done <= 1'b1;
        load_sec <= sec;
        load_ded <= ded;
        load_flags <= fl;
        @(posedge ref_clk);
        load_done <= 1'b0;
        m_p1 = 8'h80 | (sec << 6) | (ded << 5) | fl;
        m_irq |= 8;
    endtask
    initial begin
        seed = 32;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(A_PS, 0);
        rd(A_P1, 0);
        wr(A_MASK, 32'h0000000f);
        wr(A_CTRL, 32'h00000001);
        rd(A_PS, ps_exp());
        wr(A_KEY, 32'h000000a5);
        rd(A_PS, ps_exp());
        wr(A_P1, 32'h00000000);
        rd(A_PS, ps_exp());
        wr(A_KEY, 32'h000000a5);
        apb(1'b1, 16'h0000, 32'h00000000);
        m_unlock = 0;
        rd(A_PS, ps_exp());
        apb(1'b0, 16'h0000, 32'h00000000);
        check(rdata, 0);
        check({31'h0, err}, 32'h1);
        // Even rounds start clean so every fault and completion is reached.
        // Odd rounds load random flags on purpose, so misformatted pages reach the go check.
        for (i = 0; i < 16; i++) begin
            load($random(seed), $random(seed), (i % 2) ? $random(seed) : 0);
            rd(A_P1, p1_exp());
            wr(A_IRQ, 32'h0000000f);
            wr(A_MASK, $random(seed));
            wr(A_KEY, 32'h000000a5);
            wr(A_CTRL, 32'h00000001);
            rd(A_PS, ps_exp());
            rd(A_P1, p1_exp());
            if (m_busy != 0) begin
                // After a fault or a completion both status registers, the error response and the interrupt line are compared; the next go clears the error and done flags.
                finish_run((i / 2) % 6);
                rd(A_PS, ps_exp());
                rd(A_P1, p1_exp());
            end
            check(starts, m_starts);
            check(aborts, m_aborts);
        end
        report_and_stop();
    end
endmodule
